// ---- hdl/bbcm_backport.sv ----
// backport bus arbiter, sequencer, byte multiplexer, flag and command memory logic
`default_nettype none
module bbcm_backport import bbcm_pkg::*; #(
   parameter int FIFO_DEPTH = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // host window
   input wire logic i_host_valid,
   output logic o_host_ready,
   input wire logic i_host_wr,
   input wire logic i_host_long,
   input wire logic [2:0] i_host_off,
   input wire logic [31:0] i_host_wdata,
   output logic o_host_rvalid,
   input wire logic i_host_rready,
   output logic [31:0] o_host_rdata,
   output logic o_host_grant,
   // local cpu
   input wire logic i_cpu_req,
   output logic o_cpu_grant,
   input wire logic i_cpu_wr,
   input wire logic i_cpu_ser,
   input wire logic [14:0] i_cpu_addr,
   input wire logic [1:0] i_cpu_be,
   input wire logic [15:0] i_cpu_wdata,
   output logic [15:0] o_cpu_rdata,
   output logic o_cpu_done,
   // dma controller
   input wire logic i_dma_req,
   output logic o_dma_grant,
   input wire logic i_dma_to_serial,
   input wire logic [7:0] i_dma_address_lines,
   input wire logic [7:0] i_dma_data_lines,
   output logic o_dma_done,
   // serial controller
   input wire logic [7:0] i_ser_rdata,
   output logic [7:0] o_ser_wdata,
   output logic o_ser_rd_stb,
   output logic o_ser_wr_stb,
   output logic o_recovery_timer_active_n,
   // board control
   output logic o_board_reset,
   output logic o_skip_self_test_n,
   output logic o_command_memory_address_valid
);
   localparam int REC_TAIL = REC_CYC - 7;
   localparam logic [REC_W-1:0] REC_LOAD = REC_W'(REC_CYC);

   bbcm_st_type st_q;
   bbcm_st_type st_d;
   bbcm_gnt_type gnt_q;
   logic [14:0] op_addr_q;
   logic op_wr_q;
   logic [1:0] op_be_q;
   logic [31:0] op_wdata_q;
   logic op_long_q;
   logic op_byte_q;
   logic op_flag_q;
   logic op_command_memory_address_q;
   logic op_cvalid_q;
   logic [7:0] lat_hi_q;
   logic [7:0] lat_lo_q;
   logic [7:0] flag_hi_q;
   logic skip_q;
   logic command_memory_address_valid_q;
   logic [COMMAND_MEMORY_ADDRESS_W-1:0] command_memory_address_q;
   logic [REC_W-1:0] rec_cnt_q;
   logic [15:0] mem [0:RAM_WORDS-1];
   logic [15:0] ram_rd_q;
   logic [15:0] rd0_q;
   logic [15:0] rd_word;
   logic [7:0] ser_q;
   logic [15:0] cpu_q;
   logic ram_en;
   logic [14:0] ram_idx;
   logic [15:0] ram_wd;
   logic [1:0] ram_be;
   logic cur_req;
   logic start;
   logic is_dma;
   logic ser_read;
   logic rec_idle;
   logic flag_we;
   logic [14:0] host_idx;

   bbcm_stream_if #(.W(32)) rd_in ();
   bbcm_stream_if #(.W(32)) rd_out ();

   // command memory word index from the address latch
   // fixed command memory region
   function automatic logic [14:0] cmd_idx(input logic [COMMAND_MEMORY_ADDRESS_W-1:0] lat, input logic odd);
      cmd_idx = CMD_BASE_IDX | {5'h00, lat[COMMAND_MEMORY_ADDRESS_W-1:1], odd};
   endfunction

   assign is_dma = (gnt_q == G_DMA);
   // a dma ram write is a serial read; a cpu serial write is not
   assign ser_read = is_dma ? op_wr_q : ~op_wr_q;
   assign rec_idle = (rec_cnt_q == '0);
   assign o_recovery_timer_active_n = rec_idle;
   assign o_host_grant = (gnt_q == G_HOST);
   assign o_cpu_grant = (gnt_q == G_CPU);
   assign o_dma_grant = is_dma;

   // request of the current grantee
   always_comb begin
      case (gnt_q)
         G_HOST: cur_req = i_host_valid;
         G_CPU: cur_req = i_cpu_req;
         G_DMA: cur_req = i_dma_req;
         default: cur_req = 1'b0;
      endcase
   end

   // a host read only starts when its answer has room to land
   assign start = (st_q == S_IDLE) & cur_req & ((gnt_q != G_HOST) | i_host_wr | rd_in.ready);
   assign o_host_ready = start & (gnt_q == G_HOST);
   assign o_cpu_done = (st_q == S_DONE) & (gnt_q == G_CPU);
   assign o_dma_done = (st_q == S_DONE) & is_dma;

   // arbiter picks dma, then cpu, then host
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gnt_q <= G_HOST;
      end else if ((st_q == S_IDLE) && !cur_req) begin
         // moves only once the holder lets go
         if (i_dma_req) gnt_q <= G_DMA;
         else if (i_cpu_req) gnt_q <= G_CPU;
         // parked on host when nobody asks
         else gnt_q <= G_HOST;
      end
   end

   // host window decode into ram word index
   always_comb begin
      case (i_host_off)
         WIN_FLAG: host_idx = FLAG_IDX;
         WIN_COMMAND_MEMORY_ADDRESS: host_idx = COMMAND_MEMORY_ADDRESS_IDX;
         // command_memory_data 1 reaches the odd word
         WIN_CMDR1: host_idx = cmd_idx(command_memory_address_q, 1'b1);
         default: host_idx = cmd_idx(command_memory_address_q, 1'b0);
      endcase
   end

   // operation capture at start, per master
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         op_addr_q <= '0;
         op_wr_q <= 1'b0;
         op_be_q <= 2'b00;
         op_wdata_q <= '0;
         op_long_q <= 1'b0;
         op_byte_q <= 1'b0;
         op_flag_q <= 1'b0;
         op_command_memory_address_q <= 1'b0;
      end else if (start) begin
         case (gnt_q)
            G_HOST: begin
               op_addr_q <= host_idx;
               op_wr_q <= i_host_wr;
               op_be_q <= 2'b11;
               op_wdata_q <= i_host_wdata;
               op_long_q <= i_host_long & (i_host_off == WIN_CMDR0);
               op_flag_q <= (i_host_off == WIN_FLAG);
               op_command_memory_address_q <= (i_host_off == WIN_COMMAND_MEMORY_ADDRESS);
            end
            G_CPU: begin
               op_addr_q <= i_cpu_addr;
               op_wr_q <= i_cpu_wr;
               op_be_q <= i_cpu_be;
               op_wdata_q <= {16'h0000, i_cpu_wdata};
               op_long_q <= 1'b0;
               op_flag_q <= ~i_cpu_ser & (i_cpu_addr == FLAG_IDX);
               op_command_memory_address_q <= ~i_cpu_ser & (i_cpu_addr == COMMAND_MEMORY_ADDRESS_IDX);
            end
            default: begin
               // high byte arrives on the data lines
               // bit 0 stays off the ram index
               op_addr_q <= {i_dma_data_lines, i_dma_address_lines[7:1]};
               op_wr_q <= ~i_dma_to_serial;
               // even byte is the high lane
               op_be_q <= i_dma_address_lines[0] ? 2'b01 : 2'b10;
               op_byte_q <= i_dma_address_lines[0];
               op_long_q <= 1'b0;
               op_flag_q <= 1'b0;
               op_command_memory_address_q <= 1'b0;
            end
         endcase
      end
   end

   // sequencer of whichever master holds the grant
   always_comb begin
      st_d = st_q;
      case (st_q)
         S_IDLE: begin
            if (start) begin
               if ((is_dma && !i_dma_to_serial) || ((gnt_q == G_CPU) && i_cpu_ser)) st_d = S_RECW;
               else st_d = S_ACC;
            end
         end
         S_ACC: st_d = op_long_q ? S_ACC2 : (op_wr_q ? S_DONE : S_FIN);
         S_ACC2: st_d = op_wr_q ? S_DONE : S_FIN;
         S_FIN: st_d = is_dma ? S_RECW : S_DONE;
         // strobe withheld until the timer negates
         S_RECW: st_d = rec_idle ? S_SER : S_RECW;
         S_SER: st_d = (is_dma && op_wr_q) ? S_ACC : S_DONE;
         S_DONE: st_d = S_IDLE;
         default: st_d = S_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) st_q <= S_IDLE;
      else st_q <= st_d;
   end

   // ram port driven by the granted sequencer
   assign ram_en = (st_q == S_ACC) | (st_q == S_ACC2);
   assign ram_idx = (st_q == S_ACC2) ? op_addr_q + 15'h0001 : op_addr_q;
   // flag high byte never lands in ram
   assign ram_be = op_flag_q ? (op_be_q & 2'b01) : op_be_q;
   always_comb begin
      if (is_dma) ram_wd = {lat_hi_q, lat_lo_q};
      else if (st_q == S_ACC2) ram_wd = op_wdata_q[31:16];
      else ram_wd = op_wdata_q[15:0];
   end

   // buffer ram array with byte lanes, one-cycle read
   always_ff @(posedge i_clk) begin
      if (ram_en && op_wr_q) begin
         if (ram_be[1]) mem[ram_idx][15:8] <= ram_wd[15:8];
         if (ram_be[0]) mem[ram_idx][7:0] <= ram_wd[7:0];
      end
      ram_rd_q <= mem[ram_idx];
      if (st_q == S_ACC2) rd0_q <= ram_rd_q;
   end

   // read word as seen on the bus during the final cycle
   always_comb begin
      if (op_flag_q) begin
         // status bits muxed in only on a flag read, bit 11 zero
         rd_word = {flag_hi_q & FLAG_HI_MASK, ram_rd_q[7:0]};
      end else if (op_command_memory_address_q && !op_cvalid_q) begin
         rd_word = 16'h0000;
      end else begin
         // address readback is the ram shadow, not the latch
         rd_word = ram_rd_q;
      end
   end

   // host answers go through the buffer; a full buffer stalls new reads
   assign rd_in.valid = (st_q == S_FIN) & (gnt_q == G_HOST);
   assign rd_in.data = op_long_q ? {ram_rd_q, rd0_q} : {16'h0000, rd_word};
   assign rd_out.ready = i_host_rready;
   assign o_host_rvalid = rd_out.valid;
   assign o_host_rdata = rd_out.data;

   bbcm_skid_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .s_in(rd_in),
      .s_out(rd_out)
   );

   // byte latches between the 8-bit side and the word bus
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lat_hi_q <= '0;
         lat_lo_q <= '0;
      end else if ((st_q == S_FIN) && is_dma) begin
         // both latches load one ram word
         lat_hi_q <= ram_rd_q[15:8];
         lat_lo_q <= ram_rd_q[7:0];
      end else if ((st_q == S_SER) && is_dma && ser_read) begin
         // captured while read data is valid
         if (op_byte_q) lat_lo_q <= i_ser_rdata;
         else lat_hi_q <= i_ser_rdata;
      end
   end

   // serial write byte and cpu read data
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ser_q <= '0;
         cpu_q <= '0;
      end else begin
         // byte picked by address bit 0
         if (st_q == S_RECW) ser_q <= is_dma ? (op_byte_q ? lat_lo_q : lat_hi_q) : op_wdata_q[7:0];
         if ((st_q == S_FIN) && (gnt_q == G_CPU)) cpu_q <= rd_word;
         if ((st_q == S_SER) && (gnt_q == G_CPU) && ser_read) cpu_q <= {8'h00, i_ser_rdata};
      end
   end
   assign o_ser_wdata = ser_q;
   assign o_cpu_rdata = cpu_q;
   assign o_ser_rd_stb = (st_q == S_SER) & ser_read;
   assign o_ser_wr_stb = (st_q == S_SER) & ~ser_read;

   // recovery counter restarts on every serial strobe
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) rec_cnt_q <= '0;
      else if (st_q == S_SER) rec_cnt_q <= REC_LOAD;
      else if (!rec_idle) rec_cnt_q <= rec_cnt_q - REC_W'(1);
   end

   // flag written by host or cpu at ff00 only
   assign flag_we = (st_q == S_ACC) & op_flag_q & op_wr_q & op_be_q[1];

   // flag high byte, skip-test and address validity
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flag_hi_q <= FLAG_HI_RST;
         skip_q <= 1'b0;
         command_memory_address_valid_q <= 1'b0;
      end else if (flag_we) begin
         flag_hi_q <= op_wdata_q[15:8] & FLAG_HI_MASK;
         // skip-test only from a host write with reset
         skip_q <= (gnt_q == G_HOST) & op_wdata_q[8 + FLAG_RST_BIT] & op_wdata_q[8 + FLAG_SKIP_BIT];
         // address trusted only once reset bit clears
         command_memory_address_valid_q <= ~op_wdata_q[8 + FLAG_RST_BIT];
      end
   end
   // reset bit always out to the board
   assign o_board_reset = flag_hi_q[FLAG_RST_BIT];
   assign o_skip_self_test_n = ~skip_q;
   assign o_command_memory_address_valid = command_memory_address_valid_q;

   // address latch keeps bits 10:1, 10:2 address longwords
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         command_memory_address_q <= '0;
         op_cvalid_q <= 1'b0;
      end else begin
         if ((st_q == S_ACC) && op_command_memory_address_q && op_wr_q) command_memory_address_q <= op_wdata_q[COMMAND_MEMORY_ADDRESS_LSB +: COMMAND_MEMORY_ADDRESS_W];
         if (start) op_cvalid_q <= command_memory_address_valid_q;
      end
   end

   // strobe followed by eight active recovery cycles, then release REC_CYC + 1 cycles after the strobe
   sequence s_strobe;
      o_ser_rd_stb || o_ser_wr_stb;
   endsequence
   sequence s_recover;
      (!o_recovery_timer_active_n) [*8] ##REC_TAIL o_recovery_timer_active_n;
   endsequence

   a_grant_one_hot: assert property (@(posedge i_clk) disable iff (!i_rstn) $onehot(gnt_q))
      else $error("more than one grant");
   a_grant_parks_host: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (st_q == S_IDLE && !i_host_valid && !i_cpu_req && !i_dma_req) |=> gnt_q == G_HOST)
      else $error("idle grant not parked on host");
   a_grant_held_busy: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (st_q != S_IDLE) |=> $stable(gnt_q))
      else $error("grant moved during a cycle");
   a_recovery_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_strobe |-> ##1 s_recover)
      else $error("recovery time wrong");
   a_strobe_gated: assert property (@(posedge i_clk) disable iff (!i_rstn)
      s_strobe |-> $past(o_recovery_timer_active_n) && o_recovery_timer_active_n)
      else $error("serial strobe during recovery");
   a_dma_byte_latch: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_ser_rd_stb && is_dma && !op_byte_q) |=> lat_hi_q == $past(i_ser_rdata))
      else $error("even byte not latched high");
   a_dma_ram_index: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (start && is_dma) |=> op_addr_q == {$past(i_dma_data_lines), $past(i_dma_address_lines[7:1])})
      else $error("dma ram index wrong");
   a_skip_test: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (flag_we && gnt_q == G_HOST && op_wdata_q[9] && op_wdata_q[15]) |=> !o_skip_self_test_n && o_board_reset)
      else $error("skip self test not raised");
   a_command_memory_address_invalid: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_board_reset |-> !o_command_memory_address_valid)
      else $error("address valid while reset bit set");
   a_bit11_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (rd_in.valid && op_flag_q) |-> !rd_in.data[11])
      else $error("flag bit 11 not zero");
endmodule
`default_nettype wire

// ---- hdl/bbcm_pkg.sv ----
// constants, types and functional notes for the backport bus and command memory block
// Functional notes
// - byte latches join 8-bit serial path, 16-bit bus
// - dma address: low on address, high on data
// - dma address bits 15:1 drive ram index
// - dma bit 0 picks latch and ram byte
// - ram-to-serial: load word, strobe chosen byte out
// - serial-to-ram: read strobe, latch, write chosen byte
// - serial access spacing: six master clocks plus 200ns
// - recovery timer gates both sequencers' serial strobes
// - three-master arbiter; grantee's sequencer drives bus
// - idle bus parks grant on host
// - ram: 32k words, separate word index
// - four-word host window
// - command memory: 2k bytes at f000..f7ff
// - long at base+4; word 0 even, 1 odd
// - address latch keeps written bits 10:1
// - address readback comes from ram shadow word
// - address invalid after reset until reset bit clears
// - flag low byte in ram, high in logic
// - flag read muxes status bits; bit 11 zero
// - reset bit drives board reset continuously
// - host write bit9 resets; with bit15 skips test
// - flag written at ff00 by host or cpu
`default_nettype none
package bbcm_pkg;
   // clock and serial recovery timing
   localparam int CLK_NS = 25;
   localparam int SER_MCLK_NS = 100;
   localparam int REC_MCLK_CNT = 6;
   localparam int REC_EXTRA_NS = 200;
   localparam int REC_CYC = (REC_MCLK_CNT * SER_MCLK_NS + REC_EXTRA_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_W = $clog2(REC_CYC + 1);
   // buffer ram geometry
   localparam int RAM_AW = 15;
   localparam int RAM_WORDS = 32768;
   // host window byte offsets
   localparam logic [2:0] WIN_FLAG = 3'h0;
   localparam logic [2:0] WIN_COMMAND_MEMORY_ADDRESS = 3'h2;
   localparam logic [2:0] WIN_CMDR0 = 3'h4;
   localparam logic [2:0] WIN_CMDR1 = 3'h6;
   // word indices on the ram address bus
   localparam logic [14:0] FLAG_IDX = 15'h7f80;
   localparam logic [14:0] COMMAND_MEMORY_ADDRESS_IDX = 15'h7f81;
   localparam logic [14:0] CMD_BASE_IDX = 15'h7800;
   // flag high byte layout (bit n of the register is bit n-8 here)
   localparam logic [7:0] FLAG_HI_RST = 8'h02;
   localparam logic [7:0] FLAG_HI_MASK = 8'hf7;
   localparam int FLAG_RST_BIT = 1;
   localparam int FLAG_SKIP_BIT = 7;
   // command address latch
   localparam int COMMAND_MEMORY_ADDRESS_LSB = 1;
   localparam int COMMAND_MEMORY_ADDRESS_W = 10;
   // sequencer states
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_ACC  = 7'b0000010,
      S_ACC2 = 7'b0000100,
      S_FIN  = 7'b0001000,
      S_RECW = 7'b0010000,
      S_SER  = 7'b0100000,
      S_DONE = 7'b1000000
   } bbcm_st_type;
   // bus grants
   typedef enum logic [2:0] {
      G_HOST = 3'b001,
      G_CPU  = 3'b010,
      G_DMA  = 3'b100
   } bbcm_gnt_type;
endpackage
`default_nettype wire

// ---- hdl/bbcm_skid_fifo.sv ----
// small fifo holding host read answers until the host takes them
`default_nettype none
module bbcm_skid_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // streams
   bbcm_stream_if.snk s_in,
   bbcm_stream_if.src s_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // honest full and empty
   assign s_in.ready = (cnt_q != FULL);
   assign s_out.valid = (cnt_q != '0);
   assign s_out.data = mem_q[rd_q];
   assign push = s_in.valid & s_in.ready;
   assign pop = s_out.valid & s_out.ready;

   // storage, no reset needed for data
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= s_in.data;
      end
   end

   // pointers and fill count
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= nxt(wr_q);
         if (pop) rd_q <= nxt(rd_q);
         cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ---- hdl/bbcm_stream_if.sv ----
// valid/ready carrier between the sequencer and the read buffer
`default_nettype none
interface bbcm_stream_if #(parameter int W = 32) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- test/bbcm_backport_tb.sv ----
// self-checking bench for the backport bus and command memory block
`default_nettype none
module bbcm_backport_tb import bbcm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rstn = 1'b0;
   logic hv = 1'b0, hwr = 1'b0, hlong = 1'b0, hrr = 1'b0;
   logic [2:0] hoff = 3'h0;
   logic [31:0] hwd = 32'h0;
   logic creq = 1'b0, cwr = 1'b0, dreq = 1'b0, dts = 1'b0, cser = 1'b0;
   logic [14:0] caddr = 15'h0;
   logic [15:0] cwd = 16'h0;
   logic [7:0] dlo = 8'h00, dhi = 8'h00, answer = 8'h00;
   logic hready, hrvalid, hgnt, cgnt, dgnt, cdone, ddone, rd_stb, wr_stb, rec_n, brst, skip_n, cvalid;
   logic [31:0] hrdata;
   logic [15:0] crdata;
   logic [7:0] ser_rdata, ser_wdata, last_wr;
   int gap;
   int n_mismatch = 0;
   int n_checks = 0;
   bbcm_backport DUT (.i_clk(clk), .i_rstn(rstn), .i_host_valid(hv), .o_host_ready(hready), .i_host_wr(hwr),
      .i_host_long(hlong), .i_host_off(hoff), .i_host_wdata(hwd), .o_host_rvalid(hrvalid), .i_host_rready(hrr),
      .o_host_rdata(hrdata), .o_host_grant(hgnt), .i_cpu_req(creq), .o_cpu_grant(cgnt), .i_cpu_wr(cwr),
      .i_cpu_ser(cser), .i_cpu_addr(caddr), .i_cpu_be(2'h3), .i_cpu_wdata(cwd), .o_cpu_rdata(crdata),
      .o_cpu_done(cdone), .i_dma_req(dreq), .o_dma_grant(dgnt), .i_dma_to_serial(dts),
      .i_dma_address_lines(dlo), .i_dma_data_lines(dhi), .o_dma_done(ddone), .i_ser_rdata(ser_rdata),
      .o_ser_wdata(ser_wdata), .o_ser_rd_stb(rd_stb), .o_ser_wr_stb(wr_stb), .o_recovery_timer_active_n(rec_n),
      .o_board_reset(brst), .o_skip_self_test_n(skip_n), .o_command_memory_address_valid(cvalid));
   bbcm_serial_model SER (.i_clk(clk), .i_rd_stb(rd_stb), .i_wr_stb(wr_stb), .i_wdata(ser_wdata),
      .i_answer(answer), .o_rdata(ser_rdata), .o_last_wr(last_wr), .o_gap(gap));
   // free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // one comparison, counted; a miss is reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s at %0t got %h exp %h", what, $time, got, exp);
      end
   endtask
   // host request raised one negedge on, so valid is never written twice in a step
   task automatic host_set(input logic wr, input logic lng, input logic [2:0] off, input logic [31:0] wd);
      @(negedge clk);
      {hwr, hlong, hoff, hwd} = {wr, lng, off, wd};
      hv = 1'b1;
   endtask
   // hold the request until the edge that takes it, then release
   task automatic host_wait();
      int k;
      k = 0;
      #1;
      while (hready !== 1'b1 && k < 200) begin
         @(negedge clk);
         #1;
         k++;
      end
      @(negedge clk);
      hv = 1'b0;
      if (k >= 200) chk(32'h0, 32'h1, "host take");
   endtask
   task automatic host_op(input logic wr, input logic lng, input logic [2:0] off, input logic [31:0] wd);
      host_set(wr, lng, off, wd);
      host_wait();
   endtask
   // compare the waiting answer, then take it for one edge
   task automatic host_pop(input logic [31:0] exp, input logic [31:0] msk);
      int k;
      k = 0;
      @(negedge clk);
      while (hrvalid !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      chk(hrdata & msk, exp, "host read");
      hrr = 1'b1;
      @(negedge clk);
      hrr = 1'b0;
   endtask
   // wait for done under a bound; the grant must belong to the requester alone
   task automatic run_op(input logic dma);
      int k;
      k = 0;
      #1;
      while ((dma ? ddone : cdone) !== 1'b1 && k < 400) begin
         @(negedge clk);
         #1;
         k++;
      end
      chk({29'h0, hgnt, cgnt, dgnt}, {30'h0, ~dma, dma}, "grant");
      @(negedge clk);
      creq = 1'b0;
      dreq = 1'b0;
   endtask
   task automatic cpu_op(input logic wr, input logic [14:0] a, input logic [15:0] wd);
      @(negedge clk);
      {cwr, caddr, cwd} = {wr, a, wd};
      creq = 1'b1;
      run_op(1'b0);
   endtask
   task automatic dma_op(input logic ts, input logic [7:0] lo, input logic [7:0] hi);
      @(negedge clk);
      {dts, dlo, dhi} = {ts, lo, hi};
      dreq = 1'b1;
      run_op(1'b1);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #(25 * 20000);
      n_mismatch++;
      finish_test();
   end
   initial begin
      int busy;
      busy = 0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({25'h0, hgnt, cgnt, dgnt, brst, skip_n, cvalid, rec_n}, 32'h4d, "reset state");
      rstn = 1'b1;
      $display("test reset done");
      host_op(1'b1, 1'b0, WIN_FLAG, 32'h0000_fda5);
      repeat (4) @(negedge clk);
      chk({29'h0, brst, skip_n, cvalid}, 32'h3, "flag release");
      host_op(1'b0, 1'b0, WIN_FLAG, 32'h0);
      host_pop(32'h0000_f5a5, 32'h0000_ffff);
      $display("test flag done");
      host_op(1'b1, 1'b0, WIN_COMMAND_MEMORY_ADDRESS, 32'h0000_0124);
      host_op(1'b1, 1'b1, WIN_CMDR0, 32'h89ab_4567);
      host_op(1'b0, 1'b0, WIN_COMMAND_MEMORY_ADDRESS, 32'h0);
      host_pop(32'h0000_0124, 32'h0000_ffff);
      host_op(1'b0, 1'b0, WIN_CMDR0, 32'h0);
      host_op(1'b0, 1'b0, WIN_CMDR1, 32'h0);
      host_set(1'b0, 1'b1, WIN_CMDR0, 32'h0);
      // two answers wait unread, so a third read must be held off
      repeat (10) begin
         #1;
         busy += int'(hready);
         @(negedge clk);
      end
      chk(busy, 32'h0, "full buffer refusal");
      host_pop(32'h0000_4567, 32'h0000_ffff);
      host_wait();
      host_pop(32'h0000_89ab, 32'h0000_ffff);
      host_pop(32'h89ab_4567, 32'hffff_ffff);
      $display("test command memory done");
      cpu_op(1'b0, 15'h7892, 16'h0);
      chk({16'h0, crdata}, 32'h4567, "cpu read");
      cpu_op(1'b1, COMMAND_MEMORY_ADDRESS_IDX, 16'h0128);
      host_op(1'b0, 1'b0, WIN_COMMAND_MEMORY_ADDRESS, 32'h0);
      host_pop(32'h0000_0128, 32'h0000_ffff);
      chk({31'h0, hgnt}, 32'h1, "parked grant");
      $display("test cpu done");
      dma_op(1'b1, 8'h24, 8'hf1);
      chk({24'h0, last_wr}, 32'h45, "serial byte even");
      chk({31'h0, rec_n}, 32'h0, "recovery active");
      dma_op(1'b1, 8'h25, 8'hf1);
      chk({24'h0, last_wr}, 32'h67, "serial byte odd");
      chk({31'h0, gap > REC_CYC}, 32'h1, "strobe spacing");
      answer = 8'h3c;
      dma_op(1'b0, 8'h26, 8'hf1);
      chk({31'h0, gap > REC_CYC}, 32'h1, "strobe spacing");
      cpu_op(1'b0, 15'h7893, 16'h0);
      chk({16'h0, crdata}, 32'h3cab, "serial to ram");
      // cpu side of the serial controller must also wait out recovery
      cser = 1'b1;
      cpu_op(1'b1, 15'h0000, 16'h005e);
      chk({24'h0, last_wr}, 32'h5e, "cpu serial write");
      chk({31'h0, gap > REC_CYC}, 32'h1, "cpu strobe spacing");
      cpu_op(1'b0, 15'h0000, 16'h0000);
      chk({16'h0, crdata}, 32'h003c, "cpu serial read");
      chk({31'h0, gap > REC_CYC}, 32'h1, "cpu strobe spacing");
      cser = 1'b0;
      $display("test dma done");
      host_op(1'b1, 1'b0, WIN_FLAG, 32'h0000_8200);
      repeat (4) @(negedge clk);
      chk({29'h0, brst, skip_n, cvalid}, 32'h4, "board reset");
      host_op(1'b0, 1'b0, WIN_COMMAND_MEMORY_ADDRESS, 32'h0);
      host_pop(32'h0, 32'h0000_ffff);
      host_op(1'b1, 1'b0, WIN_FLAG, 32'h0);
      repeat (4) @(negedge clk);
      chk({29'h0, brst, skip_n, cvalid}, 32'h3, "reset cleared");
      $display("test board reset done");
      finish_test();
   end
endmodule
`default_nettype wire

// ---- test/bbcm_serial_model.sv ----
// serial controller stand-in: answers read strobes, records written bytes and strobe spacing
`default_nettype none
module bbcm_serial_model (
   // clock
   input wire logic i_clk,
   // strobes and data from the block
   input wire logic i_rd_stb,
   input wire logic i_wr_stb,
   input wire logic [7:0] i_wdata,
   // byte the bench wants returned on the next read strobe
   input wire logic [7:0] i_answer,
   // to the block and the bench
   output logic [7:0] o_rdata,
   output var logic [7:0] o_last_wr,
   output var int o_gap
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0;
   int last = -1000;
   logic [7:0] idle_pat = 8'h5a;
   initial o_last_wr = 8'h00;
   initial o_gap = 0;
   // data only valid under the read strobe; a moving pattern otherwise so stale values never match
   assign o_rdata = i_rd_stb ? i_answer : idle_pat;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      idle_pat <= ~idle_pat + 8'h01;
      if (i_rd_stb || i_wr_stb) begin
         o_gap <= cyc - last;
         last <= cyc;
      end
      if (i_wr_stb) begin
         o_last_wr <= i_wdata;
      end
   end
endmodule
`default_nettype wire
